//--- design/scb_pkg.sv
// Package of constants and types for the shared common block registers.
`default_nettype none
package scb_pkg;
	// ----------------------------------------------------------------
	// Widths and register numbers
	// ----------------------------------------------------------------
	localparam int unsigned DATA_W = 16;
	localparam int unsigned STAGE_W = 4;
	localparam int unsigned STAGE_COUNT = 4;
	localparam int unsigned SPARE_COUNT = 7;
	localparam logic [3:0] REG_BUSY_ACTIVE = 4'h2;
	localparam logic [3:0] REG_TICK = 4'h3;
	localparam logic [3:0] REG_TABLE_LOCK = 4'h4;
	localparam logic [3:0] REG_FAULT_ADDR = 4'h5;
	localparam logic [3:0] REG_CONTROL = 4'h6;
	localparam logic [3:0] REG_PRIVILEGE = 4'h7;
	localparam logic [3:0] REG_CROSS = 4'h8;
	localparam logic [3:0] REG_SPARE_FIRST = 4'h9;
	localparam logic [3:0] REG_SPARE_LAST = 4'hf;
	// ----------------------------------------------------------------
	// Reset values, timing points and fields
	// ----------------------------------------------------------------
	localparam logic [15:0] RESET_WORD = 16'h0000;
	localparam logic [3:0] STAGE_FULL = 4'hf;
	localparam logic [2:0] E_TICK_APPLY = 3'h7;
	localparam logic [2:0] EXEC_PROC = 3'h4;
	localparam int unsigned BUSY_HI = 15;
	localparam int unsigned BUSY_LO = 8;
	localparam int unsigned ACTIVE_HI = 7;
	localparam int unsigned ACTIVE_LO = 0;
	localparam int unsigned CCE_HI = 7;
	localparam int unsigned CCE_LO = 0;
	localparam int unsigned PRIV_HI = 7;
	localparam int unsigned PRIV_LO = 0;
	localparam int unsigned CROSS_PROC_HI = 7;
	localparam int unsigned CROSS_PROC_LO = 5;
	localparam int unsigned CROSS_REG_HI = 4;
	localparam int unsigned CROSS_REG_LO = 0;
	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		SCB_OP_WRITE = 2'h0,
		SCB_OP_TEST_SET = 2'h1,
		SCB_OP_CLEAR_LOCK = 2'h2,
		SCB_OP_SET_RESET_CTRL = 2'h3
	} scb_op_t;
	typedef struct packed {
		logic valid;
		logic [3:0] sel;
		scb_op_t op;
		logic [2:0] proc;
		logic [15:0] data;
	} scb_write_t;
endpackage
`default_nettype wire

//--- design/scb_common_regs.sv
// Shared common block registers reached by all eight processors.
// Bit numbering: documented bit n is vector bit 15-n.
`default_nettype none

// --------------------------------------------------------------------
// One binary stage of the tick counter
// --------------------------------------------------------------------
module scb_tick_stage (
	input wire logic i_ref_clk,
	input wire logic i_reset,
	input wire logic i_inc,
	output logic [3:0] o_q,
	output logic o_carry
);
	logic [3:0] q_reg;
	logic [3:0] q_next;

	assign q_next = i_inc ? q_reg + 4'h1 : q_reg;
	assign o_carry = i_inc && (q_reg == scb_pkg::STAGE_FULL);
	assign o_q = q_reg;

	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			q_reg <= 4'h0;
		end else begin
			q_reg <= q_next;
		end
	end
endmodule // scb_tick_stage

// --------------------------------------------------------------------
// Top of the common block
// --------------------------------------------------------------------
module scb_common_regs (
	// Clock and reset
	input wire logic i_ref_clk,
	input wire logic i_reset,
	// Write from the ALU fan-out
	input wire scb_pkg::scb_write_t i_write,
	// Read select
	input wire logic [3:0] i_read_sel,
	// Minor cycle timing
	input wire logic [2:0] i_minor_cycle,
	input wire logic i_e150,
	// Tick and fault capture
	input wire logic i_tick_pulse_async_n,
	input wire logic i_parity_capture_strobe_n,
	input wire logic [15:0] i_storage_addr,
	// Invoke target selection
	input wire logic i_invoke_micro_op,
	input wire logic [2:0] i_priority_proc,
	// Read and test-and-set answers
	output logic [15:0] o_read_data,
	output logic o_tas_done,
	output logic o_tas_prior,
	// Target of the current access
	output logic [2:0] o_target_proc,
	output logic [4:0] o_target_reg,
	// Per-processor controls
	output logic [7:0] o_privilege_bits,
	output logic [7:0] o_consecutive_cycle_enable
);
	// ----------------------------------------------------------------
	// Storage
	// ----------------------------------------------------------------
	logic [15:0] busy_active_reg;
	logic [15:0] table_lock_reg;
	logic [15:0] fault_addr_reg;
	logic [15:0] control_reg;
	logic [15:0] privilege_reg;
	logic [15:0] cross_reg;
	logic [15:0] spare_reg [scb_pkg::SPARE_COUNT];
	logic [15:0] read_data_reg;
	logic tas_done_reg;
	logic tas_prior_reg;
	logic [2:0] target_proc_reg;
	logic [4:0] target_reg_reg;
	logic tick_catch_reg;
	logic tick_sync_reg;
	logic tick_seen_reg;
	logic tick_pend_reg;

	// ----------------------------------------------------------------
	// Write decode
	// ----------------------------------------------------------------
	wire wr_v = i_write.valid;
	wire wr_plain = wr_v && (i_write.op == scb_pkg::SCB_OP_WRITE);
	wire wr_busy = wr_plain && (i_write.sel == scb_pkg::REG_BUSY_ACTIVE);
	wire wr_cross = wr_plain && (i_write.sel == scb_pkg::REG_CROSS);
	wire wr_priv = wr_plain && (i_write.sel == scb_pkg::REG_PRIVILEGE)
		&& (i_write.proc == scb_pkg::EXEC_PROC);
	wire wr_tas = wr_v && (i_write.op == scb_pkg::SCB_OP_TEST_SET)
		&& (i_write.sel == scb_pkg::REG_TABLE_LOCK);
	wire wr_clr = wr_v && (i_write.op == scb_pkg::SCB_OP_CLEAR_LOCK)
		&& (i_write.sel == scb_pkg::REG_TABLE_LOCK);
	wire wr_ctrl = wr_v && (i_write.op == scb_pkg::SCB_OP_SET_RESET_CTRL)
		&& (i_write.sel == scb_pkg::REG_CONTROL);
	wire wr_spare = wr_plain && (i_write.sel >= scb_pkg::REG_SPARE_FIRST);
	wire [3:0] spare_idx = i_write.sel - scb_pkg::REG_SPARE_FIRST;
	wire [3:0] rd_spare_idx = i_read_sel - scb_pkg::REG_SPARE_FIRST;

	// ----------------------------------------------------------------
	// Table locks
	// ----------------------------------------------------------------
	wire tas_prior_next = |(table_lock_reg & i_write.data);
	wire [15:0] lock_next = wr_tas ? (table_lock_reg | i_write.data)
		: wr_clr ? (table_lock_reg & ~i_write.data)
		: table_lock_reg;

	// ----------------------------------------------------------------
	// Tick path
	// ----------------------------------------------------------------
	wire tick_rise = tick_sync_reg && !tick_seen_reg && i_e150;
	wire tick_apply = (i_minor_cycle == scb_pkg::E_TICK_APPLY) && i_e150;
	wire tick_gate = tick_pend_reg && tick_apply;
	wire tick_pend_next = tick_rise || (tick_pend_reg && !tick_apply);
	logic [3:0] stage_q [scb_pkg::STAGE_COUNT];
	logic [scb_pkg::STAGE_COUNT:0] stage_inc;
	logic [15:0] tick_value;

	assign stage_inc[0] = tick_gate;
	for (genvar s = 0; s < scb_pkg::STAGE_COUNT; s++) begin : g_stage
		scb_tick_stage u_stage (
			.i_ref_clk(i_ref_clk),
			.i_reset(i_reset),
			.i_inc(stage_inc[s]),
			.o_q(stage_q[s]),
			.o_carry(stage_inc[s+1])
		);
		assign tick_value[s*4 +: 4] = stage_q[s];
	end

	// ----------------------------------------------------------------
	// Read mux and invoke target
	// ----------------------------------------------------------------
	logic [15:0] read_next;
	always_comb begin
		case (i_read_sel)
			scb_pkg::REG_BUSY_ACTIVE: read_next = busy_active_reg;
			scb_pkg::REG_TICK: read_next = tick_value;
			scb_pkg::REG_TABLE_LOCK: read_next = table_lock_reg;
			scb_pkg::REG_FAULT_ADDR: read_next = fault_addr_reg;
			scb_pkg::REG_CONTROL: read_next = control_reg;
			scb_pkg::REG_PRIVILEGE: read_next = privilege_reg;
			scb_pkg::REG_CROSS: read_next = cross_reg;
			4'h0, 4'h1: read_next = scb_pkg::RESET_WORD;
			default: read_next = spare_reg[rd_spare_idx[2:0]];
		endcase
	end
	wire [2:0] target_proc_next = i_invoke_micro_op
		? cross_reg[scb_pkg::CROSS_PROC_HI:scb_pkg::CROSS_PROC_LO]
		: i_priority_proc;
	wire [4:0] target_reg_next =
		cross_reg[scb_pkg::CROSS_REG_HI:scb_pkg::CROSS_REG_LO];

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			tick_catch_reg <= 1'b0;
			tick_sync_reg <= 1'b0;
			tick_seen_reg <= 1'b0;
			tick_pend_reg <= 1'b0;
		end else begin
			tick_catch_reg <= !i_tick_pulse_async_n;
			if (i_e150) begin
				tick_sync_reg <= tick_catch_reg;
				tick_seen_reg <= tick_sync_reg;
			end
			tick_pend_reg <= tick_pend_next;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			busy_active_reg <= scb_pkg::RESET_WORD;
			table_lock_reg <= scb_pkg::RESET_WORD;
			fault_addr_reg <= scb_pkg::RESET_WORD;
			control_reg <= scb_pkg::RESET_WORD;
			privilege_reg <= scb_pkg::RESET_WORD;
			cross_reg <= scb_pkg::RESET_WORD;
		end else begin
			if (wr_busy) busy_active_reg <= i_write.data;
			table_lock_reg <= lock_next;
			if (!i_parity_capture_strobe_n) begin
				fault_addr_reg <= i_storage_addr;
			end
			if (wr_ctrl) control_reg <= i_write.data;
			if (wr_priv) begin
				privilege_reg <= {8'h00, i_write.data[7:0]};
			end
			if (wr_cross) cross_reg <= i_write.data;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			for (int i = 0; i < scb_pkg::SPARE_COUNT; i++) begin
				spare_reg[i] <= scb_pkg::RESET_WORD;
			end
		end else if (wr_spare) begin
			spare_reg[spare_idx[2:0]] <= i_write.data;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			read_data_reg <= scb_pkg::RESET_WORD;
			tas_done_reg <= 1'b0;
			tas_prior_reg <= 1'b0;
			target_proc_reg <= 3'h0;
			target_reg_reg <= 5'h00;
		end else begin
			read_data_reg <= read_next;
			tas_done_reg <= wr_tas;
			if (wr_tas) tas_prior_reg <= tas_prior_next;
			target_proc_reg <= target_proc_next;
			target_reg_reg <= target_reg_next;
		end
	end

	assign o_read_data = read_data_reg;
	assign o_tas_done = tas_done_reg;
	assign o_tas_prior = tas_prior_reg;
	assign o_target_proc = target_proc_reg;
	assign o_target_reg = target_reg_reg;
	assign o_privilege_bits = privilege_reg[scb_pkg::PRIV_HI:scb_pkg::PRIV_LO];
	assign o_consecutive_cycle_enable =
		control_reg[scb_pkg::CCE_HI:scb_pkg::CCE_LO];

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_reset);

	a_tick_only_e7: assert property (
		!$past(i_reset) && $changed(tick_value)
		|-> $past(i_minor_cycle) == scb_pkg::E_TICK_APPLY && $past(i_e150))
		else $error("tick counter moved outside E7");
	a_tick_step_one: assert property (
		!$past(i_reset) && $changed(tick_value)
		|-> tick_value == 16'($past(tick_value) + 16'h0001))
		else $error("tick counter step is not one");
	a_tick_wraps: assert property (
		tick_gate && tick_value == 16'hffff |=> tick_value == 16'h0000)
		else $error("tick counter did not wrap to zero");
	a_low_stage_carry: assert property (
		tick_gate && stage_q[0] == 4'hf && stage_q[1] != 4'hf
		|=> stage_q[1] == 4'($past(stage_q[1]) + 4'h1) && stage_q[0] == 4'h0)
		else $error("nibble carry not passed upward");
	a_sync_to_pend: assert property (
		$rose(tick_sync_reg) |-> ##[1:40] tick_gate)
		else $error("caught tick did not reach the counter");
	a_tas_sets: assert property (
		wr_tas |=> o_tas_done && o_tas_prior == $past(tas_prior_next)
		&& ((table_lock_reg & $past(i_write.data)) == $past(i_write.data)))
		else $error("test-and-set wrong prior value or bit not set");
	a_lock_no_plain: assert property (
		!wr_tas && !wr_clr |=> $stable(table_lock_reg))
		else $error("lock bits changed without lock instruction");
	a_ctrl_only_op: assert property (
		!$past(i_reset) && $changed(control_reg) |-> $past(wr_ctrl))
		else $error("control changed without its instruction");
	a_priv_exec_only: assert property (
		wr_plain && i_write.sel == scb_pkg::REG_PRIVILEGE
		&& i_write.proc != scb_pkg::EXEC_PROC |=> $stable(privilege_reg))
		else $error("privilege written by non-executive");
	a_fault_hold: assert property (
		i_parity_capture_strobe_n |=> $stable(fault_addr_reg))
		else $error("fault address changed without strobe");
	a_invoke_target: assert property (
		i_invoke_micro_op |=> o_target_proc == $past(cross_reg[7:5]))
		else $error("invoke target not taken from cross select");
	a_read_common: assert property (
		i_read_sel == scb_pkg::REG_BUSY_ACTIVE
		|=> o_read_data == $past(busy_active_reg))
		else $error("common register read wrong value");
	a_busy_write: assert property (
		wr_busy |=> busy_active_reg == $past(i_write.data))
		else $error("busy and active word not stored");
	a_read_tick: assert property (
		i_read_sel == scb_pkg::REG_TICK
		|=> o_read_data == $past(tick_value))
		else $error("tick counter read wrong value");
	a_lock_clear: assert property (
		wr_clr |=> (table_lock_reg & $past(i_write.data)) == 16'h0000)
		else $error("clear did not release lock bits");
	a_tick_single: assert property (
		tick_gate && !tick_rise |=> !tick_pend_reg)
		else $error("applied tick left pending");
	a_top_carry: assert property (
		stage_inc[scb_pkg::STAGE_COUNT] |=> tick_value == 16'h0000)
		else $error("tick counter overflow did not clear");
	a_fault_load: assert property (
		!i_parity_capture_strobe_n
		|=> fault_addr_reg == $past(i_storage_addr))
		else $error("fault address not captured on strobe");
	a_ctrl_load: assert property (
		wr_ctrl |=> control_reg == $past(i_write.data))
		else $error("control word not stored");
	a_priv_store: assert property (
		wr_priv |=> privilege_reg == {8'h00, $past(i_write.data[7:0])})
		else $error("privilege bits not stored");
	a_priv_upper: assert property (
		privilege_reg[15:8] == 8'h00)
		else $error("unused privilege bits set");
	a_cross_write: assert property (
		wr_cross |=> cross_reg == $past(i_write.data))
		else $error("cross select not stored");
	a_target_reg: assert property (
		1'b1 |=> o_target_reg == $past(cross_reg[4:0]))
		else $error("target register not taken from cross select");
	a_priority_target: assert property (
		!i_invoke_micro_op |=> o_target_proc == $past(i_priority_proc))
		else $error("target processor not from priority logic");
	a_tas_pulse: assert property (
		!wr_tas |=> !o_tas_done)
		else $error("test-and-set done without request");

	c_tick_wrap: cover property (tick_gate && tick_value == 16'hffff);
	c_tas_busy: cover property (wr_tas && tas_prior_next);
	c_invoke: cover property (wr_cross ##[1:200] i_invoke_micro_op);
	c_nibble_carry: cover property (stage_inc[1]);
	c_fault: cover property (!i_parity_capture_strobe_n);
endmodule // scb_common_regs
`default_nettype wire

//--- tb/scb_proc_model.sv
// Model of the processor timing chain and the tick source.
`default_nettype none
module scb_proc_model (
	// Clock and reset
	input wire logic i_ref_clk,
	input wire logic i_reset,
	// Timing and tick
	output logic [2:0] o_minor_cycle,
	output logic o_e150,
	output logic o_tick_n
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] phase_reg;
	initial begin
		phase_reg = 2'h0;
		o_minor_cycle = 3'h0;
		o_tick_n = 1'b1;
	end
	// Four clocks make one minor cycle; E150 falls on the second.
	always @(posedge i_ref_clk) begin
		if (i_reset) begin
			phase_reg <= 2'h0;
			o_minor_cycle <= 3'h0;
		end else begin
			phase_reg <= phase_reg + 2'h1;
			if (phase_reg == 2'h3) begin
				o_minor_cycle <= o_minor_cycle + 3'h1;
			end
		end
	end
	assign o_e150 = (phase_reg == 2'h1) && !i_reset;
	// Sends one tick off the clock edge, then lets it reach the counter.
	task automatic send_tick(input int len);
		@(negedge i_ref_clk);
		o_tick_n = 1'b0;
		repeat (len) @(negedge i_ref_clk);
		o_tick_n = 1'b1;
		repeat (80) @(negedge i_ref_clk);
	endtask
endmodule // scb_proc_model
`default_nettype wire

//--- tb/shared_common_block_registers_bench.sv
// Self-checking bench for the shared common block registers.
`default_nettype none
module shared_common_block_registers_bench;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {
		logic [3:0] sel;
		scb_pkg::scb_op_t op;
		logic [2:0] proc;
		logic [15:0] data;
		logic [15:0] exp;
	} scb_row_t;
	logic ref_clk, reset, strobe_n, invoke, tas_done, tas_prior, tick_n, e150;
	scb_pkg::scb_write_t wr;
	logic [3:0] read_sel;
	logic [2:0] minor, prio, target_proc;
	logic [4:0] target_reg;
	logic [7:0] priv, cce;
	logic [15:0] addr, read_data, val;
	int errors = 0;
	int n_checks = 0;
	int cycles = 0;
	scb_row_t rows [13] = '{
		'{4'h2, scb_pkg::SCB_OP_WRITE, 3'h0, 16'h1234, 16'h1234},
		'{4'h2, scb_pkg::SCB_OP_WRITE, 3'h7, 16'ha55a, 16'ha55a},
		'{4'h6, scb_pkg::SCB_OP_WRITE, 3'h4, 16'hffff, 16'h0000},
		'{4'h6, scb_pkg::SCB_OP_SET_RESET_CTRL, 3'h2, 16'h0f81, 16'h0f81},
		'{4'h7, scb_pkg::SCB_OP_WRITE, 3'h1, 16'h00ff, 16'h0000},
		'{4'h7, scb_pkg::SCB_OP_WRITE, 3'h4, 16'hffa5, 16'h00a5},
		'{4'h8, scb_pkg::SCB_OP_WRITE, 3'h3, 16'h01ff, 16'h01ff},
		'{4'h3, scb_pkg::SCB_OP_WRITE, 3'h4, 16'hffff, 16'h0000},
		'{4'h4, scb_pkg::SCB_OP_WRITE, 3'h4, 16'hffff, 16'h0000},
		'{4'h5, scb_pkg::SCB_OP_WRITE, 3'h4, 16'hffff, 16'h0000},
		'{4'h9, scb_pkg::SCB_OP_WRITE, 3'h5, 16'h5a5a, 16'h5a5a},
		'{4'hf, scb_pkg::SCB_OP_WRITE, 3'h6, 16'hc3c3, 16'hc3c3},
		'{4'h0, scb_pkg::SCB_OP_WRITE, 3'h0, 16'hffff, 16'h0000}
	};
	scb_proc_model i_scb_proc_model (.i_ref_clk(ref_clk), .i_reset(reset),
		.o_minor_cycle(minor), .o_e150(e150), .o_tick_n(tick_n));
	scb_common_regs i_scb_common_regs (.i_ref_clk(ref_clk), .i_reset(reset),
		.i_write(wr), .i_read_sel(read_sel), .i_minor_cycle(minor),
		.i_e150(e150), .i_tick_pulse_async_n(tick_n),
		.i_parity_capture_strobe_n(strobe_n), .i_storage_addr(addr),
		.i_invoke_micro_op(invoke), .i_priority_proc(prio),
		.o_read_data(read_data), .o_tas_done(tas_done),
		.o_tas_prior(tas_prior), .o_target_proc(target_proc),
		.o_target_reg(target_reg), .o_privilege_bits(priv),
		.o_consecutive_cycle_enable(cce));
	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end
	task automatic check(input string name, input logic [15:0] seen,
			input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic do_write(input logic [3:0] sel, input scb_pkg::scb_op_t op,
			input logic [2:0] proc, input logic [15:0] data);
		@(posedge ref_clk);
		wr <= '{1'b1, sel, op, proc, data};
		@(posedge ref_clk);
		wr.valid <= 1'b0;
		#1;
	endtask
	task automatic do_read(input logic [3:0] sel, output logic [15:0] v);
		@(posedge ref_clk);
		read_sel <= sel;
		@(posedge ref_clk);
		#1;
		v = read_data;
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	// Cuts a hung run short.
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 5000) begin
			errors++;
			print_verdict();
		end
	end
	initial begin
		reset = 1'b1;
		wr = '0;
		read_sel = 4'h0;
		strobe_n = 1'b1;
		addr = 16'h0000;
		invoke = 1'b0;
		prio = 3'h0;
		repeat (5) @(posedge ref_clk);
		reset <= 1'b0;
		do_read(4'h3, val);
		check("tick after reset", val, 16'h0000);
		check("privilege after reset", {8'h00, priv}, 16'h0000);
		check("cce after reset", {8'h00, cce}, 16'h0000);
		check("tas done after reset", {15'h0, tas_done}, 16'h0000);
		$display("test reset done");
		foreach (rows[k]) begin
			do_write(rows[k].sel, rows[k].op, rows[k].proc, rows[k].data);
			do_read(rows[k].sel, val);
			check("register row", val, rows[k].exp);
		end
		check("cce bits", {8'h00, cce}, 16'h0081);
		check("privilege bits", {8'h00, priv}, 16'h00a5);
		$display("test table done");
		do_write(4'h4, scb_pkg::SCB_OP_TEST_SET, 3'h1, 16'h0001);
		check("tas done", {15'h0, tas_done}, 16'h0001);
		check("tas prior free", {15'h0, tas_prior}, 16'h0000);
		do_write(4'h4, scb_pkg::SCB_OP_TEST_SET, 3'h2, 16'h0003);
		check("tas prior held", {15'h0, tas_prior}, 16'h0001);
		do_write(4'h4, scb_pkg::SCB_OP_CLEAR_LOCK, 3'h3, 16'h0001);
		check("no tas on clear", {15'h0, tas_done}, 16'h0000);
		do_read(4'h4, val);
		check("lock bits", val, 16'h0002);
		$display("test lock done");
		@(posedge ref_clk);
		invoke <= 1'b1;
		prio <= 3'h2;
		repeat (2) @(posedge ref_clk);
		#1;
		check("invoke proc", {13'h0, target_proc}, 16'h0007);
		check("invoke reg", {11'h0, target_reg}, 16'h001f);
		@(posedge ref_clk);
		invoke <= 1'b0;
		repeat (2) @(posedge ref_clk);
		#1;
		check("priority proc", {13'h0, target_proc}, 16'h0002);
		$display("test invoke done");
		@(posedge ref_clk);
		addr <= 16'hbeef;
		strobe_n <= 1'b0;
		@(posedge ref_clk);
		addr <= 16'h1111;
		strobe_n <= 1'b1;
		repeat (3) @(posedge ref_clk);
		do_read(4'h5, val);
		check("fault address", val, 16'hbeef);
		$display("test fault done");
		for (int t = 0; t < 17; t++) begin
			i_scb_proc_model.send_tick((t == 5) ? 20 : 6);
		end
		do_read(4'h3, val);
		check("tick count", val, 16'h0011);
		repeat (40) @(posedge ref_clk);
		do_read(4'h3, val);
		check("tick steady", val, 16'h0011);
		$display("test tick done");
		@(posedge ref_clk);
		reset <= 1'b1;
		repeat (5) @(posedge ref_clk);
		reset <= 1'b0;
		do_read(4'h2, val);
		check("busy cleared", val, 16'h0000);
		do_read(4'h3, val);
		check("tick cleared", val, 16'h0000);
		check("cce cleared", {8'h00, cce}, 16'h0000);
		check("privilege cleared", {8'h00, priv}, 16'h0000);
		$display("test mid reset done");
		print_verdict();
	end
endmodule // shared_common_block_registers_bench
`default_nettype wire
